/* File: hw/ssc_param_bank.sv */
`timescale 1ns/10ps
module ssc_param_bank (
   input  wire logic              mclk_i,
   input  wire logic              arst_n_i,
   input  wire ssc_pkg::ssc_req_t req_i,
   input  wire ssc_pkg::ssc_func_t func_i,
   input  wire logic              alert_valid_i,
   input  wire logic [15:0]       alert_num_i,
   input  wire logic              fault_reset_i,
   input  wire logic              power_up_i,
   input  wire logic              op_torque_mode_i,
   input  wire logic              op_velocity_mode_i,
   output logic                   ack_o,
   output logic                   err_o,
   output logic [31:0]            rdata_o,
   output logic [15:0]            status_o,
   output logic [31:0]            map_ptr8_o,
   output logic [15:0]            active_mode_o,
   output logic                   io_defaults_load_o,
   output logic                   vel_limit_on_o,
   output logic                   trq_limit_on_o
);
   import ssc_pkg::*;

   logic [31:0] map_ptr8_reg;
   logic [15:0] status_reg;
   logic [15:0] last_alert_reg;
   logic [15:0] mode_ctl_reg;
   logic [15:0] active_mode_reg;
   logic [15:0] limit_en_reg;
   logic        ack_reg;
   logic        err_reg;
   logic [31:0] rdata_reg;
   logic        io_load_reg;
   logic        vel_on_reg;
   logic        trq_on_reg;

   function automatic logic [15:0] in_range(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
      in_range = {15'h0000, (v >= lo) && (v <= hi)};
   endfunction : in_range

   // Status word built from the unforced internal function states
   wire logic        warn_any    = func_i.limit_switch_hit | func_i.undervoltage |
                                   func_i.node_guard_alert | func_i.operational_stop;
   wire logic [15:0] status_next = {5'h00,
                                    warn_any,
                                    func_i.overload_alert_flag,
                                    func_i.homing_done_flag,
                                    func_i.holding_brake_flag,
                                    func_i.error_flag,
                                    func_i.torque_limit_flag,
                                    func_i.move_done_flag,
                                    func_i.speed_reached_flag,
                                    func_i.zero_speed_flag,
                                    func_i.servo_on_flag,
                                    func_i.servo_ready_flag};

   // Address decode
   wire logic hit_map   = (req_i.addr == ADDR_MAP_PTR8);
   wire logic hit_stat  = (req_i.addr == ADDR_STATUS);
   wire logic hit_alrt  = (req_i.addr == ADDR_LAST_ALRT);
   wire logic hit_mode  = (req_i.addr == ADDR_MODE_CTL);
   wire logic hit_lim   = (req_i.addr == ADDR_LIMIT_EN);
   wire logic hit_any   = hit_map | hit_stat | hit_alrt | hit_mode | hit_lim;
   wire logic mode_ok   = in_range(req_i.wdata[15:0], MODE_CTL_MIN, MODE_CTL_MAX) != 16'h0000;
   wire logic lim_ok    = in_range(req_i.wdata[15:0], 16'h0000, LIMIT_EN_MAX) != 16'h0000;
   wire logic hi_zero   = (req_i.wdata[31:16] == 16'h0000);
   wire logic wr_map    = req_i.wr & hit_map;
   wire logic wr_mode   = req_i.wr & hit_mode & mode_ok & hi_zero;
   wire logic wr_lim    = req_i.wr & hit_lim & lim_ok & hi_zero;
   wire logic wr_bad    = req_i.wr & ~(wr_map | wr_mode | wr_lim);
   wire logic rd_bad    = req_i.rd & ~hit_any;
   wire logic any_req   = req_i.rd | req_i.wr;

   wire logic [31:0] rd_mux = hit_map  ? map_ptr8_reg :
                              hit_stat ? {16'h0000, status_reg} :
                              hit_alrt ? {16'h0000, last_alert_reg} :
                              hit_mode ? {16'h0000, mode_ctl_reg} :
                              hit_lim  ? {16'h0000, limit_en_reg} : 32'h0000_0000;

   // Power-on takes over the stored mode word
   wire logic mode_change = power_up_i &
                            (mode_ctl_reg[MODE_SEL_MSB:MODE_SEL_LSB] !=
                             active_mode_reg[MODE_SEL_MSB:MODE_SEL_LSB]);
   wire logic io_load_next = mode_change & mode_ctl_reg[MODE_IORE_BIT];

   wire logic [15:0] alert_next = alert_valid_i ? alert_num_i :
                                  fault_reset_i ? LAST_ALRT_RST : last_alert_reg;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         status_reg <= STATUS_RST;
      end else begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         map_ptr8_reg <= MAP_PTR8_RST;
         mode_ctl_reg <= MODE_CTL_RST;
         limit_en_reg <= LIMIT_EN_RST;
      end else begin
         if (wr_map) begin
            map_ptr8_reg <= req_i.wdata;
         end
         if (wr_mode) begin
            mode_ctl_reg <= req_i.wdata[15:0];
         end
         if (wr_lim) begin
            limit_en_reg <= req_i.wdata[15:0];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         active_mode_reg <= MODE_CTL_RST;
         io_load_reg     <= 1'b0;
      end else begin
         if (power_up_i) begin
            active_mode_reg <= mode_ctl_reg;
         end
         io_load_reg <= io_load_next;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         last_alert_reg <= LAST_ALRT_RST;
      end else begin
         last_alert_reg <= alert_next;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack_reg   <= 1'b0;
         err_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ack_reg   <= any_req;
         err_reg   <= wr_bad | rd_bad;
         rdata_reg <= req_i.rd ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         vel_on_reg <= 1'b0;
         trq_on_reg <= 1'b0;
      end else begin
         vel_on_reg <= limit_en_reg[LIM_VEL_BIT] & op_torque_mode_i;
         trq_on_reg <= limit_en_reg[LIM_TRQ_BIT] & op_velocity_mode_i;
      end
   end

   assign ack_o              = ack_reg;
   assign err_o              = err_reg;
   assign rdata_o            = rdata_reg;
   assign status_o           = status_reg;
   assign map_ptr8_o         = map_ptr8_reg;
   assign active_mode_o      = active_mode_reg;
   assign io_defaults_load_o = io_load_reg;
   assign vel_limit_on_o     = vel_on_reg;
   assign trq_limit_on_o     = trq_on_reg;

   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_mode_write;
      req_i.wr && hit_mode && mode_ok && hi_zero && !power_up_i;
   endsequence

   sequence s_power_change;
      power_up_i && mode_change;
   endsequence

   property p_status_low;
      1'b1 |=> status_o[5:0] == {$past(func_i.torque_limit_flag),
                                 $past(func_i.move_done_flag),
                                 $past(func_i.speed_reached_flag),
                                 $past(func_i.zero_speed_flag),
                                 $past(func_i.servo_on_flag),
                                 $past(func_i.servo_ready_flag)};
   endproperty
   a_status_low: assert property (p_status_low) else $error("status low bits wrong");

   property p_status_high;
      1'b1 |=> status_o[9:6] == {$past(func_i.overload_alert_flag),
                                 $past(func_i.homing_done_flag),
                                 $past(func_i.holding_brake_flag),
                                 $past(func_i.error_flag)};
   endproperty
   a_status_high: assert property (p_status_high) else $error("status high bits wrong");

   property p_reserved;
      status_o[15:11] == 5'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved status bits set");

   property p_warn;
      (func_i.limit_switch_hit || func_i.undervoltage || func_i.node_guard_alert ||
       func_i.operational_stop) |=> status_o[ST_WARN];
   endproperty
   a_warn: assert property (p_warn) else $error("warning bit not set");

   property p_status_ro;
      (req_i.wr && hit_stat) |=> ack_o && err_o;
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status write not refused");

   property p_alert_clear;
      (fault_reset_i && !alert_valid_i) |=> last_alert_reg == 16'h0000;
   endproperty
   a_alert_clear: assert property (p_alert_clear) else $error("alert not cleared");

   property p_map_write;
      (req_i.wr && hit_map) ##1 (req_i.rd && hit_map && !req_i.wr) |=>
         rdata_o == $past(req_i.wdata, 2);
   endproperty
   a_map_write: assert property (p_map_write) else $error("pointer readback wrong");

   property p_keep_io;
      (s_power_change and (mode_ctl_reg[MODE_IORE_BIT] == 1'b0)) |=> !io_defaults_load_o;
   endproperty
   a_keep_io: assert property (p_keep_io) else $error("I/O reloaded with field 0");

   property p_load_io;
      (s_power_change and mode_ctl_reg[MODE_IORE_BIT]) |=> io_defaults_load_o;
   endproperty
   a_load_io: assert property (p_load_io) else $error("I/O defaults not loaded");

   property p_deferred;
      s_mode_write |=> $stable(active_mode_o);
   endproperty
   a_deferred: assert property (p_deferred) else $error("mode applied before power-on");

   property p_mode_range;
      (mode_ctl_reg >= MODE_CTL_MIN) && (mode_ctl_reg <= MODE_CTL_MAX);
   endproperty
   a_mode_range: assert property (p_mode_range) else $error("mode word out of range");

   property p_vel_lim;
      (limit_en_reg[LIM_VEL_BIT] && op_torque_mode_i) |=> vel_limit_on_o;
   endproperty
   a_vel_lim: assert property (p_vel_lim) else $error("velocity limit not on");

   property p_trq_lim;
      !op_velocity_mode_i |=> !trq_limit_on_o;
   endproperty
   a_trq_lim: assert property (p_trq_lim) else $error("torque limit on outside mode");

   property p_alert_set;
      alert_valid_i |=> last_alert_reg == $past(alert_num_i);
   endproperty
   a_alert_set: assert property (p_alert_set) else $error("alert number not kept");

   property p_req_ack;
      (req_i.rd || req_i.wr) |=> ack_o;
   endproperty
   a_req_ack: assert property (p_req_ack) else $error("request not acknowledged");

   property p_map_hold;
      !wr_map |=> $stable(map_ptr8_o);
   endproperty
   a_map_hold: assert property (p_map_hold) else $error("pointer changed");

   property p_mode_refused;
      (req_i.wr && hit_mode && !wr_mode) |=> $stable(mode_ctl_reg) && err_o;
   endproperty
   a_mode_refused: assert property (p_mode_refused) else $error("mode write taken");

   property p_power_apply;
      power_up_i |=> active_mode_o == $past(mode_ctl_reg);
   endproperty
   a_power_apply: assert property (p_power_apply) else $error("mode not applied");

   property p_vel_off;
      !op_torque_mode_i |=> !vel_limit_on_o;
   endproperty
   a_vel_off: assert property (p_vel_off) else $error("velocity limit on");

   property p_trq_on;
      (limit_en_reg[LIM_TRQ_BIT] && op_velocity_mode_i) |=> trq_limit_on_o;
   endproperty
   a_trq_on: assert property (p_trq_on) else $error("torque limit not on");

endmodule : ssc_param_bank

/* File: hw/ssc_pkg.sv */
package ssc_pkg;

   // Parameter addresses seen by the fieldbus
   localparam logic [15:0] ADDR_MAP_PTR8  = 16'h0154;
   localparam logic [15:0] ADDR_STATUS    = 16'h015C;
   localparam logic [15:0] ADDR_LAST_ALRT = 16'h015E;
   localparam logic [15:0] ADDR_MODE_CTL  = 16'h0202;
   localparam logic [15:0] ADDR_LIMIT_EN  = 16'h0204;

   // Reset (factory) values and legal ranges
   localparam logic [31:0] MAP_PTR8_RST   = 32'h0000_0000;
   localparam logic [15:0] STATUS_RST     = 16'h0000;
   localparam logic [15:0] LAST_ALRT_RST  = 16'h0000;
   localparam logic [15:0] MODE_CTL_RST   = 16'h0099;
   localparam logic [15:0] MODE_CTL_MIN   = 16'h0020;
   localparam logic [15:0] MODE_CTL_MAX   = 16'h1199;
   localparam logic [15:0] LIMIT_EN_RST   = 16'h0000;
   localparam logic [15:0] LIMIT_EN_MAX   = 16'h0011;

   // Mode control word fields
   localparam int MODE_SEL_LSB  = 0;
   localparam int MODE_SEL_MSB  = 7;
   localparam int MODE_DIR_BIT  = 8;
   localparam int MODE_IORE_BIT = 12;

   // Limitation enable word fields
   localparam int LIM_VEL_BIT = 0;
   localparam int LIM_TRQ_BIT = 4;

   // Status word bit positions
   localparam int ST_READY   = 0;
   localparam int ST_SRV_ON  = 1;
   localparam int ST_ZERO_SPEED_FLAG    = 2;
   localparam int ST_SPD_OK  = 3;
   localparam int ST_MOVE    = 4;
   localparam int ST_TRQ     = 5;
   localparam int ST_ERR     = 6;
   localparam int ST_BRAKE   = 7;
   localparam int ST_HOMED   = 8;
   localparam int ST_OVLD    = 9;
   localparam int ST_WARN    = 10;
   localparam int ST_RSV_LSB = 11;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [31:0] wdata;
   } ssc_req_t;

   typedef struct packed {
      logic servo_ready_flag;
      logic servo_on_flag;
      logic zero_speed_flag;
      logic speed_reached_flag;
      logic move_done_flag;
      logic torque_limit_flag;
      logic error_flag;
      logic holding_brake_flag;
      logic homing_done_flag;
      logic overload_alert_flag;
      logic limit_switch_hit;
      logic undervoltage;
      logic node_guard_alert;
      logic operational_stop;
   } ssc_func_t;

endpackage : ssc_pkg

/* File: bench/ssc_bus_master.sv */
`timescale 1ns/10ps
module ssc_bus_master (
   input  wire logic         mclk_i,
   output ssc_pkg::ssc_req_t req_o,
   input  wire logic         ack_i,
   input  wire logic         err_i,
   input  wire logic [31:0]  rdata_i
);
   import ssc_pkg::*;
   initial req_o = '0;
   // One request cycle, then idle with inverted lines so stale values never match
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      int n;
      q = '1;
      e = 1'b1;
      @(posedge mclk_i);
      req_o <= {!w, w, a, d};
      for (n = 0; n < 4; n++) begin
         @(posedge mclk_i);
         if (n == 0) req_o <= {1'b0, 1'b0, ~a, ~d};
         #1;
         if (ack_i === 1'b1) begin
            q = rdata_i;
            e = err_i;
            break;
         end
      end
   endtask : xfer
endmodule : ssc_bus_master

/* File: bench/tb.sv */
`timescale 1ns/10ps
module tb;
   import ssc_pkg::*;
   logic        mclk_i, arst_n_i, alert_valid_i, fault_reset_i, power_up_i;
   logic        op_torque_mode_i, op_velocity_mode_i, ack_o, err_o, e;
   logic        io_defaults_load_o, vel_limit_on_o, trq_limit_on_o;
   logic [15:0] alert_num_i, status_o, active_mode_o;
   logic [31:0] rdata_o, map_ptr8_o, q;
   ssc_req_t    req_i;
   ssc_func_t   func_i;
   int          bad_count = 0;
   int          checks = 0;

   ssc_param_bank u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .req_i(req_i),
      .func_i(func_i), .alert_valid_i(alert_valid_i), .alert_num_i(alert_num_i),
      .fault_reset_i(fault_reset_i), .power_up_i(power_up_i),
      .op_torque_mode_i(op_torque_mode_i), .op_velocity_mode_i(op_velocity_mode_i),
      .ack_o(ack_o), .err_o(err_o), .rdata_o(rdata_o), .status_o(status_o),
      .map_ptr8_o(map_ptr8_o), .active_mode_o(active_mode_o),
      .io_defaults_load_o(io_defaults_load_o), .vel_limit_on_o(vel_limit_on_o),
      .trq_limit_on_o(trq_limit_on_o));
   ssc_bus_master u_mst (.mclk_i(mclk_i), .req_o(req_i), .ack_i(ack_o),
      .err_i(err_o), .rdata_i(rdata_o));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic ex);
      u_mst.xfer(1'b0, a, 32'h0000_0000, q, e);
      chk(q, x);
      chk({31'h0, e}, {31'h0, ex});
   endtask : rd
   // Writes answer with zero data whether taken or refused
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic ex);
      u_mst.xfer(1'b1, a, d, q, e);
      chk(q, 32'h0000_0000);
      chk({31'h0, e}, {31'h0, ex});
   endtask : wr
   task automatic pwr(input logic [15:0] m, input logic ld);
      @(posedge mclk_i);
      power_up_i <= 1'b1;
      @(posedge mclk_i);
      power_up_i <= 1'b0;
      #1;
      chk({16'h0, active_mode_o}, {16'h0, m});
      chk({31'h0, io_defaults_load_o}, {31'h0, ld});
      @(posedge mclk_i);
      #1;
      chk({31'h0, io_defaults_load_o}, 32'h0000_0000);
   endtask : pwr
   task automatic end_of_test;
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   initial begin
      repeat (3000) @(posedge mclk_i);
      bad_count++;
      end_of_test();
   end

   initial begin
      arst_n_i = 1'b0;
      alert_valid_i = 1'b0;
      fault_reset_i = 1'b0;
      power_up_i = 1'b0;
      op_torque_mode_i = 1'b0;
      op_velocity_mode_i = 1'b0;
      alert_num_i = 16'h0000;
      func_i = '0;
      repeat (12) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      chk({16'h0, active_mode_o}, 32'h0000_0099);
      rd(ADDR_MAP_PTR8, 32'h0000_0000, 1'b0);
      rd(ADDR_STATUS, 32'h0000_0000, 1'b0);
      rd(ADDR_LAST_ALRT, 32'h0000_0000, 1'b0);
      rd(ADDR_MODE_CTL, 32'h0000_0099, 1'b0);
      rd(ADDR_LIMIT_EN, 32'h0000_0000, 1'b0);
      rd(16'h0156, 32'h0000_0000, 1'b1);
      wr(ADDR_MAP_PTR8, 32'h012C_012C, 1'b0);
      chk(map_ptr8_o, 32'h012C_012C);
      wr(ADDR_MAP_PTR8, 32'hFFFF_FFFF, 1'b0);
      rd(ADDR_MAP_PTR8, 32'hFFFF_FFFF, 1'b0);
      // Walk one function at a time; last four all map onto the warning bit
      for (int i = 0; i < 14; i++) begin
         @(posedge mclk_i);
         func_i <= ssc_func_t'(14'h2000 >> i);
         @(posedge mclk_i);
         #1;
         chk({16'h0, status_o}, (i < 11) ? (32'h1 << i) : 32'h0000_0400);
      end
      @(posedge mclk_i);
      func_i <= '1;
      @(posedge mclk_i);
      #1;
      chk({16'h0, status_o}, 32'h0000_07FF);
      rd(ADDR_STATUS, 32'h0000_07FF, 1'b0);
      wr(ADDR_STATUS, 32'h0000_0000, 1'b1);
      rd(ADDR_STATUS, 32'h0000_07FF, 1'b0);
      @(posedge mclk_i);
      alert_valid_i <= 1'b1;
      alert_num_i <= 16'hBEEF;
      @(posedge mclk_i);
      alert_valid_i <= 1'b0;
      rd(ADDR_LAST_ALRT, 32'h0000_BEEF, 1'b0);
      wr(ADDR_LAST_ALRT, 32'h0000_0000, 1'b1);
      @(posedge mclk_i);
      fault_reset_i <= 1'b1;
      @(posedge mclk_i);
      fault_reset_i <= 1'b0;
      rd(ADDR_LAST_ALRT, 32'h0000_0000, 1'b0);
      // A new alert in the cycle of a fault reset is kept
      @(posedge mclk_i);
      alert_valid_i <= 1'b1;
      fault_reset_i <= 1'b1;
      alert_num_i <= 16'h0123;
      @(posedge mclk_i);
      alert_valid_i <= 1'b0;
      fault_reset_i <= 1'b0;
      rd(ADDR_LAST_ALRT, 32'h0000_0123, 1'b0);
      wr(ADDR_MODE_CTL, 32'h0000_001F, 1'b1);
      wr(ADDR_MODE_CTL, 32'h0000_119A, 1'b1);
      wr(ADDR_MODE_CTL, 32'h0001_1005, 1'b1);
      wr(ADDR_MODE_CTL, 32'h0000_1005, 1'b0);
      chk({16'h0, active_mode_o}, 32'h0000_0099);
      rd(ADDR_MODE_CTL, 32'h0000_1005, 1'b0);
      pwr(16'h1005, 1'b1);
      wr(ADDR_MODE_CTL, 32'h0000_0021, 1'b0);
      pwr(16'h0021, 1'b0);
      wr(ADDR_LIMIT_EN, 32'h0000_0012, 1'b1);
      wr(ADDR_LIMIT_EN, 32'h0000_0011, 1'b0);
      for (int j = 0; j < 4; j++) begin
         @(posedge mclk_i);
         op_torque_mode_i <= j[0];
         op_velocity_mode_i <= j[1];
         @(posedge mclk_i);
         #1;
         chk({30'h0, vel_limit_on_o, trq_limit_on_o}, {30'h0, j[0], j[1]});
      end
      wr(ADDR_LIMIT_EN, 32'h0000_0010, 1'b0);
      @(posedge mclk_i);
      #1;
      chk({30'h0, vel_limit_on_o, trq_limit_on_o}, 32'h0000_0001);
      end_of_test();
   end
endmodule : tb
